// *** shared/afsc_defs.svh ***
`ifndef AFSC_DEFS_SVH
`define AFSC_DEFS_SVH

// Register index of setup 0; byte address is four times the index
`define AFSC_IDX_FILT0    6'h28
// Number of setups, one filter configuration word each
`define AFSC_NUM_SETUP    8
// Reset value of every filter configuration word
`define AFSC_CFG_RST      16'h0000
// Reserved bits 14:12 and 7 in normal mode
`define AFSC_RSVD_MASK    16'h7080

// Field positions
`define AFSC_B_DIRECT     15
`define AFSC_B_PFEN       11
`define AFSC_PF_HI        10
`define AFSC_PF_LO        8
`define AFSC_FT_HI        6
`define AFSC_FT_LO        5
`define AFSC_RT_HI        4
`define AFSC_RT_LO        0
`define AFSC_DEC_HI       14

// Direct mode decimation multiplier is 32, applied as a shift
`define AFSC_DECIM_SHIFT  5
// Filter type code of sinc5 plus sinc1
`define AFSC_FT_SINC5     2'h0
// Highest documented rate code
`define AFSC_RATE_MAX     5'h17

// Post filter select codes
`define AFSC_PF_2727      3'h2
`define AFSC_PF_2500      3'h3
`define AFSC_PF_2000      3'h5
`define AFSC_PF_1667      3'h6
// Post filter rates in hundredths of a sample per second
`define AFSC_PF_2727_CSPS 22'haa7
`define AFSC_PF_2500_CSPS 22'h9c4
`define AFSC_PF_2000_CSPS 22'h7d0
`define AFSC_PF_1667_CSPS 22'h683
// Post filter rejection in dB
`define AFSC_PF_2727_DB   7'h2f
`define AFSC_PF_2500_DB   7'h3e
`define AFSC_PF_2000_DB   7'h56
`define AFSC_PF_1667_DB   7'h5c
// Post filter settling times in microseconds (36.67, 40, 50, 60 ms)
`define AFSC_PF_2727_US   32'h8f3e
`define AFSC_PF_2500_US   32'h9c40
`define AFSC_PF_2000_US   32'hc350
`define AFSC_PF_1667_US   32'hea60
// Bus clock in MHz
`define AFSC_CLK_MHZ      32'h28

`endif

// *** shared/afsc_pkg.sv ***
`default_nettype none
package afsc_pkg;
  // One filter configuration word
  typedef logic [15:0] afsc_cfg_t;
  // Rate in hundredths of a sample per second
  typedef logic [21:0] afsc_rate_t;
  // Settling tracker states
  typedef enum logic [0:0] {
    AFSC_ST_IDLE,
    AFSC_ST_SETTLE
  } afsc_settle_e;
endpackage
`default_nettype wire

// *** src/afsc_filter_cfg.sv ***
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "afsc_defs.svh"
module afsc_filter_cfg
  import afsc_pkg::*;
#(
  parameter int unsigned APB_AW      = 8,                              // APB address width
  parameter int unsigned SET_2727_CYC = `AFSC_PF_2727_US * `AFSC_CLK_MHZ, // Settling, 27.27 SPS
  parameter int unsigned SET_2500_CYC = `AFSC_PF_2500_US * `AFSC_CLK_MHZ, // Settling, 25 SPS
  parameter int unsigned SET_2000_CYC = `AFSC_PF_2000_US * `AFSC_CLK_MHZ, // Settling, 20 SPS
  parameter int unsigned SET_1667_CYC = `AFSC_PF_1667_US * `AFSC_CLK_MHZ  // Settling, 16.67 SPS
) (
  input  wire logic              pclk,                // Bus clock, 40 MHz
  input  wire logic              presetn,             // Async reset, active low
  input  wire logic              psel,                // APB select
  input  wire logic              penable,             // APB access phase
  input  wire logic              pwrite,              // APB write
  input  wire logic [APB_AW-1:0] paddr,               // APB byte address
  input  wire logic [31:0]       pwdata,              // APB write data
  input  wire logic [3:0]        pstrb,               // APB byte strobes
  output logic      [31:0]       prdata,              // APB read data
  output logic                   pready,              // APB ready
  output logic                   pslverr,             // APB error, unmapped
  input  wire logic [2:0]        active_setup,        // Setup in use by datapath
  input  wire logic              mod_tick,            // One pulse per modulator sample
  output logic                   conv_restart,        // Abort and restart pulse
  output logic      [2:0]        restart_setup,       // Setup that was written
  output logic                   direct_mode,         // Direct decimation mode
  output logic      [1:0]        filter_type_select,  // Filter type
  output logic      [4:0]        output_rate_code,    // Rate code
  output logic      [2:0]        post_filter_select,  // Post filter code
  output logic                   post_filter_active,  // Post filter in effect
  output logic      [19:0]       decim_ratio,         // Direct decimation, 32N
  output afsc_rate_t             rate_centi_sps,      // Rate, hundredths of SPS
  output logic                   rate_code_valid,     // Rate known from table
  output logic      [6:0]        post_reject_db,      // Post filter rejection
  output logic                   settle_busy,         // Post filter settling
  output logic                   sample_tick          // Direct mode sample pulse
);

  // Address hits one of the configuration words
  function automatic logic cfg_hit(input logic [APB_AW-1:0] a);
    logic [APB_AW-3:0] idx;
    idx     = a[APB_AW-1:2];
    cfg_hit = (a[1:0] == 2'h0) &&
              (idx[APB_AW-3:3] == (APB_AW-5)'(`AFSC_IDX_FILT0 >> 3));
  endfunction

  // Setup number from the address
  function automatic logic [2:0] cfg_slot(input logic [APB_AW-1:0] a);
    cfg_slot = a[4:2];
  endfunction

  // Merge write data by strobes; reserved bits clear outside direct mode
  function automatic afsc_cfg_t cfg_merge(input afsc_cfg_t old, input logic [31:0] w,
                                          input logic [3:0] s);
    afsc_cfg_t v;
    v = old;
    if (s[0]) begin
      v[7:0] = w[7:0];
    end
    if (s[1]) begin
      v[15:8] = w[15:8];
    end
    if (!v[`AFSC_B_DIRECT]) begin
      v = v & ~`AFSC_RSVD_MASK;
    end
    cfg_merge = v;
  endfunction

  // Settling cycles of a post filter code
  function automatic logic [21:0] pf_settle(input logic [2:0] c);
    case (c)
      `AFSC_PF_2727: pf_settle = 22'(SET_2727_CYC);
      `AFSC_PF_2500: pf_settle = 22'(SET_2500_CYC);
      `AFSC_PF_2000: pf_settle = 22'(SET_2000_CYC);
      `AFSC_PF_1667: pf_settle = 22'(SET_1667_CYC);
      default:       pf_settle = 22'h000000;
    endcase
  endfunction

  afsc_cfg_t    cfg_ff [`AFSC_NUM_SETUP];  // Configuration words
  logic [31:0]  prdata_ff;                 // Read data
  logic         restart_ff;                // Restart pulse
  logic [2:0]   restart_setup_ff;          // Written setup
  logic         direct_ff;                 // Registered decode
  logic [1:0]   ftype_ff;
  logic [4:0]   rcode_ff;
  logic [2:0]   pfsel_ff;
  logic         pfact_ff;
  logic [19:0]  decim_ff;
  afsc_rate_t   rate_ff;
  logic         rvalid_ff;
  logic [6:0]   pfdb_ff;
  afsc_settle_e state_ff;                  // Settling tracker
  logic [21:0]  settle_cnt_ff;             // Settling cycles left
  logic [19:0]  gap_ff;                    // Modulator samples counted
  logic         tick_ff;                   // Sample pulse
  logic         wr_take;                   // Write accepted
  logic         rd_setup;                  // Read setup phase
  afsc_cfg_t    cur;                       // Word of the active setup
  logic         nxt_direct;
  logic [1:0]   nxt_ftype;
  logic         nxt_pfact;
  logic [19:0]  nxt_decim;
  afsc_rate_t   nxt_rate;
  logic         nxt_rvalid;
  logic [6:0]   nxt_pfdb;
  afsc_rate_t   lut_rate;                  // Table rate
  logic         lut_valid;                 // Table hit

  // Zero wait state slave; error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~cfg_hit(paddr);
  assign wr_take = psel & penable & pwrite & cfg_hit(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;

  // Configuration words, all eight alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `AFSC_NUM_SETUP; i++) begin
        cfg_ff[i] <= `AFSC_CFG_RST;
      end
    end else if (wr_take) begin
      cfg_ff[cfg_slot(paddr)] <= cfg_merge(cfg_ff[cfg_slot(paddr)], pwdata, pstrb);
    end
  end

  // Read data captured in the setup phase, upper half zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (rd_setup) begin
      if (cfg_hit(paddr)) begin
        prdata_ff <= {16'h0000, cfg_ff[cfg_slot(paddr)]};
      end else begin
        prdata_ff <= 32'h00000000;  // Unmapped reads zero
      end
    end
  end
  assign prdata = prdata_ff;

  // Any accepted write restarts the conversion sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_ff       <= 1'b0;
      restart_setup_ff <= 3'h0;
    end else begin
      restart_ff <= wr_take;
      if (wr_take) begin
        restart_setup_ff <= cfg_slot(paddr);
      end
    end
  end
  assign conv_restart  = restart_ff;
  assign restart_setup = restart_setup_ff;

  // Rate lookup for the active setup
  afsc_rate_lut u_lut (
    .rate_code  (cur[`AFSC_RT_HI:`AFSC_RT_LO]),
    .sinc3      (cur[`AFSC_FT_HI:`AFSC_FT_LO] != `AFSC_FT_SINC5),
    .rate_csps  (lut_rate),
    .rate_valid (lut_valid)
  );

  // Decode of the active setup
  always_comb begin
    cur        = cfg_ff[active_setup];
    nxt_direct = cur[`AFSC_B_DIRECT];
    nxt_ftype  = cur[`AFSC_FT_HI:`AFSC_FT_LO];
    nxt_decim  = 20'h00000;
    nxt_pfact  = 1'b0;
    nxt_rate   = lut_rate;
    nxt_rvalid = lut_valid;
    nxt_pfdb   = 7'h00;
    if (nxt_direct) begin
      // Other options ignored; ratio is 32 times bits 14:0
      nxt_ftype  = 2'h0;
      nxt_rate   = 22'h000000;
      nxt_rvalid = 1'b0;
      nxt_decim  = {cur[`AFSC_DEC_HI:0], 5'h00};
    end else if (cur[`AFSC_B_PFEN] && nxt_ftype == `AFSC_FT_SINC5) begin
      // Post filter overrides the table rate
      nxt_pfact = 1'b1;
      case (cur[`AFSC_PF_HI:`AFSC_PF_LO])
        `AFSC_PF_2727: begin
          nxt_rate = `AFSC_PF_2727_CSPS;
          nxt_pfdb = `AFSC_PF_2727_DB;
        end
        `AFSC_PF_2500: begin
          nxt_rate = `AFSC_PF_2500_CSPS;
          nxt_pfdb = `AFSC_PF_2500_DB;
        end
        `AFSC_PF_2000: begin
          nxt_rate = `AFSC_PF_2000_CSPS;
          nxt_pfdb = `AFSC_PF_2000_DB;
        end
        `AFSC_PF_1667: begin
          nxt_rate = `AFSC_PF_1667_CSPS;
          nxt_pfdb = `AFSC_PF_1667_DB;
        end
        default: begin
          // Undocumented code: post filter stays off
          nxt_pfact = 1'b0;
        end
      endcase
    end
  end

  // Registered decode outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_ff <= 1'b0;
      ftype_ff  <= 2'h0;
      rcode_ff  <= 5'h00;
      pfsel_ff  <= 3'h0;
      pfact_ff  <= 1'b0;
      decim_ff  <= 20'h00000;
      rate_ff   <= 22'h000000;
      rvalid_ff <= 1'b0;
      pfdb_ff   <= 7'h00;
    end else begin
      direct_ff <= nxt_direct;
      ftype_ff  <= nxt_ftype;
      rcode_ff  <= cur[`AFSC_RT_HI:`AFSC_RT_LO];
      pfsel_ff  <= cur[`AFSC_PF_HI:`AFSC_PF_LO];
      pfact_ff  <= nxt_pfact;
      decim_ff  <= nxt_decim;
      rate_ff   <= nxt_rate;
      rvalid_ff <= nxt_rvalid;
      pfdb_ff   <= nxt_pfdb;
    end
  end
  assign direct_mode        = direct_ff;
  assign filter_type_select = ftype_ff;
  assign output_rate_code   = rcode_ff;
  assign post_filter_select = pfsel_ff;
  assign post_filter_active = pfact_ff;
  assign decim_ratio        = decim_ff;
  assign rate_centi_sps     = rate_ff;
  assign rate_code_valid    = rvalid_ff;
  assign post_reject_db     = pfdb_ff;

  // Settling tracker, started by a restart with the post filter on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff      <= AFSC_ST_IDLE;
      settle_cnt_ff <= 22'h000000;
    end else begin
      case (state_ff)
        AFSC_ST_IDLE: begin
          if (restart_ff && nxt_pfact) begin
            state_ff      <= AFSC_ST_SETTLE;
            settle_cnt_ff <= pf_settle(cur[`AFSC_PF_HI:`AFSC_PF_LO]);
          end
        end
        AFSC_ST_SETTLE: begin
          if (restart_ff) begin
            // New write starts the wait over, or ends it
            state_ff      <= nxt_pfact ? AFSC_ST_SETTLE : AFSC_ST_IDLE;
            settle_cnt_ff <= pf_settle(cur[`AFSC_PF_HI:`AFSC_PF_LO]);
          end else if (settle_cnt_ff <= 22'h000001) begin
            state_ff      <= AFSC_ST_IDLE;
            settle_cnt_ff <= 22'h000000;
          end else begin
            settle_cnt_ff <= settle_cnt_ff - 22'h000001;
          end
        end
        default: begin
          state_ff <= AFSC_ST_IDLE;
        end
      endcase
    end
  end
  assign settle_busy = (state_ff == AFSC_ST_SETTLE);

  // Direct mode sample pulse every 32N modulator samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff  <= 20'h00000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (restart_ff || !direct_ff || decim_ff == 20'h00000) begin
        gap_ff <= 20'h00000;
      end else if (mod_tick) begin
        if (gap_ff == decim_ff - 20'h00001) begin
          gap_ff  <= 20'h00000;
          tick_ff <= 1'b1;
        end else begin
          gap_ff <= gap_ff + 20'h00001;
        end
      end
    end
  end
  assign sample_tick = tick_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr;
    psel && penable && pwrite && cfg_hit(paddr);
  endsequence

  a_write_restart: assert property (s_wr |=> conv_restart && restart_setup == $past(paddr[4:2]))
    else $error("write did not restart conversion");
  a_restart_single: assert property (conv_restart && !wr_take |=> !conv_restart)
    else $error("restart pulse too long");
  a_upper_zero: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_direct_ignore: assert property (direct_mode |-> !post_filter_active && !rate_code_valid)
    else $error("options active in direct mode");
  a_tick_direct: assert property (sample_tick |-> $past(direct_ff) && decim_ratio[4:0] == 5'h00)
    else $error("sample pulse outside direct mode");
  a_pf_type: assert property (post_filter_active |-> filter_type_select == `AFSC_FT_SINC5)
    else $error("post filter with wrong type");
  a_pf_rate: assert property (post_filter_active |-> rate_centi_sps inside {`AFSC_PF_2727_CSPS,
      `AFSC_PF_2500_CSPS, `AFSC_PF_2000_CSPS, `AFSC_PF_1667_CSPS})
    else $error("post filter rate wrong");
  a_settle_hold: assert property ($rose(settle_busy) |-> settle_busy [*8])
    else $error("settling ended too soon");
  a_top_rate: assert property (rate_code_valid && !post_filter_active && output_rate_code <= 5'h05
      |-> rate_centi_sps == 22'h2faf08)
    else $error("top rate wrong");
  a_slow_rate: assert property (rate_code_valid && !post_filter_active && output_rate_code == `AFSC_RATE_MAX
      |-> rate_centi_sps == 22'h00007d)
    else $error("slowest rate wrong");
  a_unmapped_err: assert property (psel && penable && !cfg_hit(paddr) |-> pslverr ##1 !conv_restart)
    else $error("unmapped access not refused");

endmodule
`default_nettype wire

// *** src/afsc_rate_lut.sv ***
`timescale 1ns/1ps
`default_nettype none
module afsc_rate_lut
  import afsc_pkg::*;
(
  input  wire logic [4:0] rate_code,  // Output rate code
  input  wire logic       sinc3,      // Sinc3 filter selected
  output afsc_rate_t      rate_csps,  // Rate, hundredths of SPS
  output logic            rate_valid  // Code is in the table
);
  // Code to rate table; sinc3 differs on a few codes
  always_comb begin
    rate_valid = 1'b1;
    case (rate_code)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: rate_csps = 22'h2faf08;
      5'h06: rate_csps = 22'h112a88;
      5'h07: rate_csps = 22'h11bd04;
      5'h08: rate_csps = 22'h0fe524;
      5'h09: rate_csps = 22'h07f260;
      5'h0a: rate_csps = sinc3 ? 22'h03f930 : 22'h03f674;
      5'h0b: rate_csps = sinc3 ? 22'h0189c0 : 22'h01895c;
      5'h0c: rate_csps = sinc3 ? 22'h00c4e0 : 22'h00c4cc;
      5'h0d: rate_csps = sinc3 ? 22'h009c7c : 22'h0094d4;
      5'h0e: rate_csps = 22'h004e3e;
      5'h0f: rate_csps = 22'h002742;
      5'h10: rate_csps = sinc3 ? 22'h00176e : 22'h001740;
      5'h11: rate_csps = sinc3 ? 22'h001388 : 22'h001368;
      5'h12: rate_csps = 22'h0007d1;
      5'h13: rate_csps = sinc3 ? 22'h000683 : 22'h00067f;
      5'h14: rate_csps = 22'h0003e8;
      5'h15: rate_csps = 22'h0001f4;
      5'h16: rate_csps = 22'h0000fa;
      5'h17: rate_csps = 22'h00007d;
      default: begin
        // Undocumented code: no rate
        rate_csps  = 22'h000000;
        rate_valid = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import afsc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite;  // Bus clock, reset, controls
  logic [7:0]  paddr;                                  // Byte address
  logic [31:0] pwdata, prdata;                         // Write and read data
  logic [3:0]  pstrb;                                  // Byte strobes
  logic        pready, pslverr;                        // Slave answer
  logic [2:0]  active_setup, restart_setup, pfs;       // Setup in use, last written, post code
  logic        mod_tick, conv_restart, direct_mode;    // Modulator pulse, restart, direct
  logic [1:0]  fts;                                    // Filter type
  logic [4:0]  orc;                                    // Rate code
  logic        pfa, rate_code_valid, settle_busy;      // Decode flags
  logic        sample_tick;                            // Direct mode sample pulse
  logic [19:0] decim_ratio;                            // Direct decimation
  afsc_rate_t  rate_centi_sps;                         // Rate in 0.01 SPS
  logic [6:0]  post_reject_db;                         // Rejection in dB
  logic [31:0] rd;                                     // Last read data
  logic        err;                                    // Last error flag
  int          errors, total_checks;                   // Verdict counters
  int          restarts, busy_cnt, tick_cnt;           // Pulse and level counters
  logic [2:0]  pfc [4] = '{3'h2, 3'h3, 3'h5, 3'h6};                 // Post filter codes
  logic [21:0] pfr [4] = '{22'haa7, 22'h9c4, 22'h7d0, 22'h683};     // Their rates
  logic [6:0]  pfd [4] = '{7'h2f, 7'h3e, 7'h56, 7'h5c};             // Their rejection
  logic [15:0] rw  [4] = '{16'h0017, 16'h000a, 16'h002a, 16'h0018}; // Rate test words
  logic [21:0] rx  [4] = '{22'h7d, 22'h3f674, 22'h3f930, 22'h0};    // Expected rates

  // Short settling counts keep the run brief
  afsc_filter_cfg #(
    .SET_2727_CYC (20),
    .SET_2500_CYC (20),
    .SET_2000_CYC (20),
    .SET_1667_CYC (20)
  ) DUT (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .active_setup       (active_setup),
    .mod_tick           (mod_tick),
    .conv_restart       (conv_restart),
    .restart_setup      (restart_setup),
    .direct_mode        (direct_mode),
    .filter_type_select (fts),
    .output_rate_code   (orc),
    .post_filter_select (pfs),
    .post_filter_active (pfa),
    .decim_ratio        (decim_ratio),
    .rate_centi_sps     (rate_centi_sps),
    .rate_code_valid    (rate_code_valid),
    .post_reject_db     (post_reject_db),
    .settle_busy        (settle_busy),
    .sample_tick        (sample_tick)
  );

  // Bus clock, 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Counts pulses and busy cycles as seen at each edge
  always @(posedge pclk) begin
    if (conv_restart === 1'b1) restarts++;
    if (settle_busy === 1'b1) busy_cnt++;
    if (sample_tick === 1'b1) tick_cnt++;
  end

  // Compares one value and records a mismatch
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready, takes answer at that edge
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Writes one word, then lets the decode settle
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    apb_xfer(1'b1, a, {16'h0, d}, 4'h3);
    repeat (3) @(posedge pclk);
    #1;
  endtask

  // Prints counts and the verdict, then stops
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #(25 * 40000);
    errors++;
    summarize();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, mod_tick} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    active_setup = 3'h0;
    {errors, total_checks, restarts, busy_cnt, tick_cnt} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check(32'(rate_centi_sps), 32'h2faf08);
    check(32'(rate_code_valid), 32'h1);
    for (int k = 0; k < 8; k++) begin
      apb_xfer(1'b0, 8'ha0 + 8'(4 * k), 32'h0, 4'h0);
      check(rd, 32'h0);
      check(32'(err), 32'h0);
    end
    $display("test reset done");

    // Write aborts, reserved bits stay zero, strobes
    apb_xfer(1'b1, 8'ha0, 32'h7fff, 4'h3);
    #1;
    check(32'(conv_restart), 32'h1);
    @(posedge pclk);
    #1;
    check(32'(conv_restart), 32'h0);
    check(32'(restart_setup), 32'h0);
    check(32'(restarts), 32'h1);
    apb_xfer(1'b0, 8'ha0, 32'h0, 4'h0);
    check(rd, 32'h0f7f);
    check({fts, orc, pfs}, {22'h0, 2'h3, 5'h1f, 3'h7});
    check(32'(rate_code_valid), 32'h0);
    apb_xfer(1'b1, 8'ha4, 32'hffff, 4'h1);
    apb_xfer(1'b0, 8'ha4, 32'h0, 4'h0);
    check(rd, 32'h007f);
    $display("test write done");

    // Rate table: fast codes, slowest code, sinc3 variant, invalid code
    for (int c = 0; c < 6; c++) begin
      wreg(8'ha0, 16'(c));
      check(32'(rate_centi_sps), 32'h2faf08);
    end
    for (int i = 0; i < 4; i++) begin
      wreg(8'ha0, rw[i]);
      check(32'(rate_centi_sps), 32'(rx[i]));
      check(32'(rate_code_valid), (i == 3) ? 32'h0 : 32'h1);
    end
    $display("test rates done");

    // Post filters: rate, rejection, settling length on a restart
    for (int i = 0; i < 4; i++) begin
      wreg(8'ha0, {4'h0, 1'b1, pfc[i], 8'h00});
      check(32'(pfa), 32'h1);
      check(32'(rate_centi_sps), 32'(pfr[i]));
      check(32'(post_reject_db), 32'(pfd[i]));
      repeat (50) @(posedge pclk);
      #1;
      busy_cnt = 0;
      wreg(8'ha0, {4'h0, 1'b1, pfc[i], 8'h00});
      repeat (50) @(posedge pclk);
      #1;
      check(32'(busy_cnt), 32'd20);
    end
    busy_cnt = 0;
    wreg(8'ha0, 16'h0b20);
    check(32'(pfa), 32'h0);
    wreg(8'ha0, 16'h0300);
    check(32'(pfa), 32'h0);
    wreg(8'ha0, 16'h0c00);
    check(32'(pfa), 32'h0);
    check(32'(rate_centi_sps), 32'h2faf08);
    repeat (30) @(posedge pclk);
    #1;
    check(32'(busy_cnt), 32'h0);
    $display("test post filter done");

    // Direct decimation: other options ignored, 32N ratio, tick count
    wreg(8'ha0, 16'hfa02);
    check(32'({direct_mode, pfa, decim_ratio}), {10'h0, 2'h2, 20'hf4040});
    check(32'(rate_centi_sps), 32'h0);
    apb_xfer(1'b0, 8'ha0, 32'h0, 4'h0);
    check(rd, 32'hfa02);
    wreg(8'ha0, 16'h8002);
    check(32'(decim_ratio), 32'h40);
    tick_cnt = 0;
    @(posedge pclk);
    mod_tick <= 1'b1;
    repeat (130) @(posedge pclk);
    mod_tick <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    check(32'(tick_cnt), 32'h2);
    $display("test direct done");

    // Other setups apply only when selected
    wreg(8'hac, 16'h0017);
    check(32'(restart_setup), 32'h3);
    check(32'(direct_mode), 32'h1);
    @(posedge pclk);
    active_setup <= 3'h3;
    repeat (3) @(posedge pclk);
    #1;
    check(32'({direct_mode, rate_centi_sps}), 32'h7d);
    @(posedge pclk);
    active_setup <= 3'h0;
    $display("test setups done");

    // Unmapped and misaligned accesses are refused
    repeat (4) @(posedge pclk);
    #1;
    restarts = 0;
    apb_xfer(1'b1, 8'hc0, 32'hffff, 4'h3);
    check(32'(err), 32'h1);
    apb_xfer(1'b1, 8'ha1, 32'hffff, 4'h3);
    check(32'(err), 32'h1);
    apb_xfer(1'b0, 8'hc0, 32'h0, 4'h0);
    check({rd[30:0], err}, 32'h1);
    repeat (3) @(posedge pclk);
    #1;
    check(32'(restarts), 32'h0);
    apb_xfer(1'b0, 8'ha0, 32'h0, 4'h0);
    check(rd, 32'h8002);
    $display("test unmapped done");
    summarize();
  end
endmodule
`default_nettype wire
